// ---- src/fepc_map.svh ----
// Constants of the fast Ethernet coding path: code groups, seeds and counts.
`ifndef FEPC_MAP_SVH
`define FEPC_MAP_SVH

// ----------------------------------------------------------------------------
// Control code groups, leftmost bit sent first
// ----------------------------------------------------------------------------
`define FEPC_CG_IDLE 5'h1F
`define FEPC_CG_J 5'h18
`define FEPC_CG_K 5'h11
`define FEPC_CG_T 5'h0D
`define FEPC_CG_R 5'h07
`define FEPC_CG_H 5'h04
`define FEPC_JK_PAIR 10'h311

// ----------------------------------------------------------------------------
// Scrambler and line timing
// ----------------------------------------------------------------------------
`define FEPC_LFSR_W 11
`define FEPC_LFSR_TAP_HI 10
`define FEPC_LFSR_TAP_LO 8
`define FEPC_LFSR_SEED 11'h7FF
`define FEPC_GROUP_BITS 5
`define FEPC_BIT_LAST 3'h4
`define FEPC_BIT_PRELOAD 3'h3
`define FEPC_PREAMBLE_NIB 4'h5
`define FEPC_LOCK_BITS 7'h3C
`define FEPC_EDGE_GAP_MAX 6'h3F

`endif

// ---- src/fepc_pkg.sv ----
// Types and code-group tables of the fast Ethernet coding path.
`include "fepc_map.svh"

package fepc_pkg;

  // --------------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } fepc_mii_tx_s;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] d;
  } fepc_mii_rx_s;

  typedef enum logic [1:0] {
    FEPC_LVL_ZERO,
    FEPC_LVL_PLUS,
    FEPC_LVL_MINUS
  } fepc_lvl_e;

  // --------------------------------------------------------------------------
  // Data code-group table
  // --------------------------------------------------------------------------
  function automatic logic [4:0] fepc_enc(input logic [3:0] nib);
    logic [4:0] cg;
    case (nib)
      4'h0: cg = 5'h1E;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0A;
      4'h5: cg = 5'h0B;
      4'h6: cg = 5'h0E;
      4'h7: cg = 5'h0F;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'hA: cg = 5'h16;
      4'hB: cg = 5'h17;
      4'hC: cg = 5'h1A;
      4'hD: cg = 5'h1B;
      4'hE: cg = 5'h1C;
      default: cg = 5'h1D;
    endcase
    return cg;
  endfunction : fepc_enc

  // Returns {valid, nibble}; anything outside the data table is invalid.
  function automatic logic [4:0] fepc_dec(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++)
    begin
      if (fepc_enc(4'(i)) == cg)
      begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : fepc_dec

endpackage : fepc_pkg

// ---- src/fepc_lfsr.sv ----
// Eleven-bit scrambler key generator, shared by transmit and receive.
`timescale 1ns/10ps
`include "fepc_map.svh"

module fepc_lfsr
  import fepc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic load_en_i,
  input wire logic load_bit_i,
  // Key
  output logic key_o
);

  logic [`FEPC_LFSR_W-1:0] state;

  // Feedback of x^11 + x^9 + 1 gives a period of 2047 bits.
  assign key_o = state[`FEPC_LFSR_TAP_HI] ^ state[`FEPC_LFSR_TAP_LO];

  // While loading, received key bits are shifted in so a far-end key is learned.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= `FEPC_LFSR_SEED;
    end
    else
    begin
      state <= {state[`FEPC_LFSR_W-2:0], load_en_i ? load_bit_i : key_o};
    end
  end

endmodule : fepc_lfsr

// ---- src/fepc_top.sv ----
// Digital coding path of a 100 Mbps twisted-pair transceiver.
//
// Overview of operation
// - Serialise MII transmit nibbles to a bit stream.
// - Encode 4B/5B first, then scramble.
// - Scrambled bits go NRZI, then MLT-3 out.
// - Scrambler is an 11-bit LFSR.
// - 2047-bit sequence, receiver descrambles with same.
// - Received MLT-3 levels become an NRZI stream.
// - Take one bit per clock; NRZI edges only detect silence; make NRZ.
// - Descramble first, then 4B/5B decode.
// - Deserialise decoded groups to MII receive nibbles.
`timescale 1ns/10ps
`include "fepc_map.svh"

module fepc_top
  import fepc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // MII transmit side from the MAC
  input wire fepc_mii_tx_s tx_i,
  output logic tx_take_o,
  // Line transmit side
  output fepc_lvl_e tx_line_o,
  // Line receive side from the slicer
  input wire fepc_lvl_e rx_line_i,
  // MII receive side to the MAC
  output fepc_mii_rx_s rx_o,
  output logic rx_stb_o,
  // Status
  output logic rx_lock_o
);

  typedef enum {TX_IDLE, TX_K, TX_DATA, TX_R} fepc_tx_e;
  typedef enum {RX_HUNT, RX_FRAME} fepc_rx_e;

  // --------------------------------------------------------------------------
  // Transmit serialiser and encoder
  // --------------------------------------------------------------------------
  // Each clock carries one code bit; a group takes five clocks.
  logic [2:0] tx_bcnt;
  logic [4:0] tx_sreg;
  logic [4:0] next_cg;
  fepc_tx_e tx_st;
  fepc_tx_e next_tx_st;
  logic tx_key;
  logic tx_scr;
  logic tx_nrzi;
  logic tx_nrzi_d;
  logic [1:0] tx_phase;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_bcnt <= 3'h0;
    end
    else
    begin
      tx_bcnt <= (tx_bcnt == `FEPC_BIT_LAST) ? 3'h0 : tx_bcnt + 3'h1;
    end
  end

  // The MAC is told one cycle ahead so its nibble stands on the loading edge.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_take_o <= 1'b0;
    end
    else
    begin
      tx_take_o <= (tx_bcnt == `FEPC_BIT_PRELOAD);
    end
  end

  // The first preamble octet is replaced by the start delimiter pair.
  always_comb
  begin
    next_cg = `FEPC_CG_IDLE;
    next_tx_st = tx_st;
    case (tx_st)
      TX_IDLE:
      begin
        if (tx_i.en)
        begin
          next_cg = `FEPC_CG_J;
          next_tx_st = TX_K;
        end
      end
      TX_K:
      begin
        next_cg = `FEPC_CG_K;
        next_tx_st = TX_DATA;
      end
      TX_DATA:
      begin
        if (!tx_i.en)
        begin
          next_cg = `FEPC_CG_T;
          next_tx_st = TX_R;
        end
        else if (tx_i.er)
        begin
          next_cg = `FEPC_CG_H;
        end
        else
        begin
          next_cg = fepc_enc(tx_i.d);
        end
      end
      TX_R:
      begin
        next_cg = `FEPC_CG_R;
        next_tx_st = TX_IDLE;
      end
      default:
      begin
        next_tx_st = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_st <= TX_IDLE;
      tx_sreg <= `FEPC_CG_IDLE;
    end
    else if (tx_bcnt == `FEPC_BIT_LAST)
    begin
      tx_st <= next_tx_st;
      tx_sreg <= next_cg;
    end
    else
    begin
      tx_sreg <= {tx_sreg[3:0], 1'b0};
    end
  end

  // --------------------------------------------------------------------------
  // Transmit scrambler, NRZI and MLT-3
  // --------------------------------------------------------------------------
  fepc_lfsr u_tx_lfsr (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .load_en_i(1'b0),
    .load_bit_i(1'b0),
    .key_o(tx_key)
  );

  assign tx_scr = tx_sreg[4] ^ tx_key;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_nrzi <= 1'b0;
      tx_nrzi_d <= 1'b0;
    end
    else
    begin
      tx_nrzi <= tx_nrzi ^ tx_scr;
      tx_nrzi_d <= tx_nrzi;
    end
  end

  // MLT-3 walks zero, plus, zero, minus on every NRZI transition.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_phase <= 2'h0;
      tx_line_o <= FEPC_LVL_ZERO;
    end
    else if (tx_nrzi != tx_nrzi_d)
    begin
      tx_phase <= tx_phase + 2'h1;
      case (tx_phase + 2'h1)
        2'h1: tx_line_o <= FEPC_LVL_PLUS;
        2'h3: tx_line_o <= FEPC_LVL_MINUS;
        default: tx_line_o <= FEPC_LVL_ZERO;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Receive front end: MLT-3 to NRZI to NRZ, edge tracking
  // --------------------------------------------------------------------------
  fepc_lvl_e rx_s1;
  fepc_lvl_e rx_s2;
  fepc_lvl_e rx_s3;
  logic rx_nrzi;
  logic rx_nrzi_d;
  logic rx_nrz;
  logic [5:0] rx_gap;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_s1 <= FEPC_LVL_ZERO;
      rx_s2 <= FEPC_LVL_ZERO;
      rx_s3 <= FEPC_LVL_ZERO;
    end
    else
    begin
      rx_s1 <= rx_line_i;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_nrzi <= 1'b0;
      rx_nrzi_d <= 1'b0;
    end
    else
    begin
      rx_nrzi <= rx_nrzi ^ (rx_s2 != rx_s3);
      rx_nrzi_d <= rx_nrzi;
    end
  end

  assign rx_nrz = rx_nrzi ^ rx_nrzi_d;

  // Each clock carries one bit; NRZI edges restart the gap count, and a long silence means no signal.
  // Scrambled idle keeps edges dense, so the gap limit is generous.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_gap <= `FEPC_EDGE_GAP_MAX;
    end
    else if (rx_nrz)
    begin
      rx_gap <= 6'h00;
    end
    else if (rx_gap != `FEPC_EDGE_GAP_MAX)
    begin
      rx_gap <= rx_gap + 6'h01;
    end
  end

  // --------------------------------------------------------------------------
  // Descrambler
  // --------------------------------------------------------------------------
  logic rx_key;
  logic rx_plain;
  logic dsc_lock;
  logic [6:0] dsc_cnt;

  // Idle is all ones, so the key bit is the inverted line bit until locked.
  fepc_lfsr u_rx_lfsr (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .load_en_i(!dsc_lock),
    .load_bit_i(!rx_nrz),
    .key_o(rx_key)
  );

  assign rx_plain = rx_nrz ^ rx_key;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      dsc_lock <= 1'b0;
      dsc_cnt <= 7'h00;
    end
    else if (rx_gap == `FEPC_EDGE_GAP_MAX)
    begin
      dsc_lock <= 1'b0;
      dsc_cnt <= 7'h00;
    end
    else if (!dsc_lock)
    begin
      dsc_cnt <= rx_plain ? dsc_cnt + 7'h01 : 7'h00;
      dsc_lock <= rx_plain && (dsc_cnt == `FEPC_LOCK_BITS - 7'h01);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_lock_o <= 1'b0;
    end
    else
    begin
      rx_lock_o <= dsc_lock;
    end
  end

  // --------------------------------------------------------------------------
  // Receive alignment, decoder and deserialiser
  // --------------------------------------------------------------------------
  logic [8:0] rx_win;
  logic [4:0] rx_cg;
  logic [4:0] rx_dec;
  logic [2:0] rx_bcnt;
  fepc_rx_e rx_st;

  assign rx_cg = {rx_win[3:0], rx_plain};
  assign rx_dec = fepc_dec(rx_cg);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_win <= 9'h000;
    end
    else
    begin
      rx_win <= {rx_win[7:0], rx_plain};
    end
  end

  // Groups are framed by the start delimiter; the delimiter pair is
  // handed on as a single preamble nibble, half of a preamble octet.
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_st <= RX_HUNT;
      rx_bcnt <= 3'h0;
      rx_o <= '0;
      rx_stb_o <= 1'b0;
    end
    else
    begin
      rx_stb_o <= 1'b0;
      case (rx_st)
        RX_HUNT:
        begin
          // The last reported state stands until the next strobe, so the MAC never sees
          // a change of the receive nibble without a strobe beside it.
          if (dsc_lock && {rx_win, rx_plain} == `FEPC_JK_PAIR)
          begin
            rx_st <= RX_FRAME;
            rx_bcnt <= 3'h0;
            rx_o <= '{dv: 1'b1, er: 1'b0, d: `FEPC_PREAMBLE_NIB};
            rx_stb_o <= 1'b1;
          end
        end
        RX_FRAME:
        begin
          if (!dsc_lock)
          begin
            rx_st <= RX_HUNT;
            rx_o <= '0;
            rx_stb_o <= 1'b1;
          end
          else if (rx_bcnt != `FEPC_BIT_LAST)
          begin
            rx_bcnt <= rx_bcnt + 3'h1;
          end
          else
          begin
            rx_bcnt <= 3'h0;
            rx_stb_o <= 1'b1;
            if (rx_cg == `FEPC_CG_T)
            begin
              rx_st <= RX_HUNT;
              rx_o <= '0;
            end
            else if (rx_cg == `FEPC_CG_IDLE)
            begin
              // Idle inside a frame is a premature end and is reported.
              rx_st <= RX_HUNT;
              rx_o <= '{dv: 1'b0, er: 1'b1, d: 4'h0};
            end
            else if (rx_cg == `FEPC_CG_K)
            begin
              rx_o <= '{dv: 1'b1, er: 1'b0, d: `FEPC_PREAMBLE_NIB};
            end
            else
            begin
              rx_o <= '{dv: 1'b1, er: !rx_dec[4], d: rx_dec[3:0]};
            end
          end
        end
        default:
        begin
          rx_st <= RX_HUNT;
        end
      endcase
    end
  end

endmodule : fepc_top

// ---- tb/fepc_properties.sv ----
// Port checks of the coding path, bound to its top module.
`timescale 1ns/10ps

module fepc_properties
  import fepc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire fepc_mii_tx_s tx_i,
  input wire logic tx_take_o,
  input wire fepc_lvl_e tx_line_o,
  input wire fepc_lvl_e rx_line_i,
  input wire fepc_mii_rx_s rx_o,
  input wire logic rx_stb_o,
  input wire logic rx_lock_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------------
  // Line quiet counter
  // ----------------------------------------------------------------------
  // It saturates, so a long dead cable cannot wrap it back to a small value.
  fepc_lvl_e prev_line;
  logic [6:0] quiet;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      prev_line <= FEPC_LVL_ZERO;
      quiet <= 7'h00;
    end
    else
    begin
      prev_line <= rx_line_i;
      if (rx_line_i != prev_line)
        quiet <= 7'h00;
      else if (quiet != 7'h7F)
        quiet <= quiet + 7'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  chk_take_spacing: assert property (tx_take_o |=> !tx_take_o [*4] ##1 tx_take_o)
    else $error("transmit take pulses not five clocks apart");
  chk_mlt_plus: assert property (tx_line_o == FEPC_LVL_PLUS |=> tx_line_o != FEPC_LVL_MINUS)
    else $error("line jumped from plus to minus");
  chk_mlt_minus: assert property (tx_line_o == FEPC_LVL_MINUS |=> tx_line_o != FEPC_LVL_PLUS)
    else $error("line jumped from minus to plus");
  chk_level_legal: assert property (tx_line_o inside {FEPC_LVL_ZERO, FEPC_LVL_PLUS, FEPC_LVL_MINUS})
    else $error("line level outside the three levels");
  chk_nibble_gap: assert property (rx_stb_o && rx_o.dv |=> !rx_stb_o [*4] ##1 rx_stb_o)
    else $error("receive nibbles not five clocks apart");
  chk_rx_hold: assert property ($changed(rx_o) |-> rx_stb_o)
    else $error("receive nibble changed without strobe");
  chk_frame_locked: assert property (rx_stb_o && rx_o.dv |-> rx_lock_o)
    else $error("frame nibble delivered while unlocked");
  chk_silence_unlock: assert property (quiet >= 7'h48 |-> !rx_lock_o)
    else $error("lock held on a silent line");
  chk_unlocked_quiet: assert property (!rx_lock_o [*3] |-> !rx_o.dv)
    else $error("frame valid while unlocked");

  cover property ($rose(rx_lock_o));
  cover property ($fell(rx_lock_o));
  cover property (rx_stb_o && rx_o.dv && rx_o.er);
endmodule : fepc_properties

bind fepc_top fepc_properties u_props (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_i(tx_i),
  .tx_take_o(tx_take_o), .tx_line_o(tx_line_o), .rx_line_i(rx_line_i), .rx_o(rx_o),
  .rx_stb_o(rx_stb_o), .rx_lock_o(rx_lock_o));

// ---- tb/fepc_mac_model.sv ----
// Behavioural MAC on the MII side of the coding path.
`timescale 1ns/10ps

module fepc_mac_model
  import fepc_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Transmit towards the block
  input wire logic take_i,
  output fepc_mii_tx_s tx_o,
  // Receive from the block
  input wire fepc_mii_rx_s rx_i,
  input wire logic stb_i
);
  // Entries are {er, nibble}; an empty queue ends the frame.
  logic [4:0] txq[$];
  fepc_mii_rx_s rxq[$];
  logic [4:0] nxt;

  initial tx_o = '0;

  always @(posedge clk_i)
  begin
    if (stb_i)
      rxq.push_back(rx_i);
    if (take_i)
    begin
      #1;
      if (txq.size() > 0)
      begin
        nxt = txq.pop_front();
        tx_o = {1'b1, nxt};
      end
      else
        tx_o = '0;
    end
  end
endmodule : fepc_mac_model

// ---- tb/fepc_top_tb.sv ----
// Self-checking bench of the coding path in line loopback.
`timescale 1ns/10ps

module fepc_top_tb
  import fepc_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cut = 1'b0;
  fepc_mii_tx_s tx_i;
  logic tx_take_o;
  logic rx_stb_o;
  logic rx_lock_o;
  fepc_lvl_e tx_line_o;
  fepc_lvl_e rx_line_i;
  fepc_mii_rx_s rx_o;
  int miscompares = 0;
  int checked = 0;

  always #10 clk_i = ~clk_i;
  // The cut stands for a dead cable, which the slicer reads as zero.
  assign rx_line_i = cut ? FEPC_LVL_ZERO : tx_line_o;

  fepc_top dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .tx_i(tx_i), .tx_take_o(tx_take_o),
    .tx_line_o(tx_line_o), .rx_line_i(rx_line_i), .rx_o(rx_o), .rx_stb_o(rx_stb_o),
    .rx_lock_o(rx_lock_o));
  fepc_mac_model mac (.clk_i(clk_i), .take_i(tx_take_o), .tx_o(tx_i), .rx_i(rx_o),
    .stb_i(rx_stb_o));

  // ----------------------------------------------------------------------
  // Compare and wait helpers
  // ----------------------------------------------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_rx(input string name, input fepc_mii_rx_s exp, input fepc_mii_rx_s got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_rx

  task automatic wait_lock(input logic want, input int limit);
    for (int i = 0; i < limit && rx_lock_o !== want; i++)
      @(posedge clk_i);
    #1;
  endtask : wait_lock

  // Sends one frame and compares every strobed nibble; errored nibbles skip data.
  task automatic run_frame(input logic [4:0] nib[$]);
    fepc_mii_rx_s exp[$];
    fepc_mii_rx_s got;
    mac.rxq.delete();
    exp.push_back(fepc_mii_rx_s'({2'b10, 4'h5}));
    foreach (nib[i])
      if (i > 1)
        exp.push_back(fepc_mii_rx_s'({1'b1, nib[i][4], nib[i][4] ? 4'h0 : nib[i][3:0]}));
    exp.push_back(fepc_mii_rx_s'(6'h00));
    foreach (nib[i])
      mac.txq.push_back(nib[i]);
    for (int i = 0; i < 900 && !(mac.rxq.size() > 0 && mac.rxq[$].dv === 1'b0); i++)
      @(posedge clk_i);
    chk_bit("rx_count", 1'b1, mac.rxq.size() == exp.size());
    foreach (exp[i])
    begin
      got = (i < mac.rxq.size()) ? mac.rxq[i] : 'x;
      if (exp[i].er)
        got.d = 4'h0;
      chk_rx("rx_nibble", exp[i], got);
    end
  endtask : run_frame

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_lock();
    wait_lock(1'b1, 400);
    chk_bit("lock", 1'b1, rx_lock_o);
  endtask : t_lock

  task automatic t_all_codes();
    logic [4:0] q[$];
    q = '{5'h05, 5'h05};
    for (int i = 0; i < 16; i++)
      q.push_back({1'b0, 4'(i)});
    run_frame(q);
  endtask : t_all_codes

  task automatic t_dead_line();
    @(posedge clk_i);
    #1 cut = 1'b1;
    wait_lock(1'b0, 80);
    chk_bit("lock_lost", 1'b0, rx_lock_o);
    cut = 1'b0;
    wait_lock(1'b1, 400);
    chk_bit("relock", 1'b1, rx_lock_o);
  endtask : t_dead_line

  task automatic t_error_nibble();
    run_frame('{5'h05, 5'h05, 5'h0A, 5'h13, 5'h0C});
  endtask : t_error_nibble

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (12) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    t_lock();
    t_all_codes();
    t_dead_line();
    t_error_nibble();
    tally_and_finish();
  end

  // All scenarios together need some 400 clocks.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule : fepc_top_tb
